// file: logic/imc_pkg.sv
package imc_pkg;
    // Byte address of the register word on the bus
    localparam logic [31:0] IMC_SRC26_27_ADDR = 32'hffffe018;
    localparam logic [31:0] IMC_SRC28_31_ADDR = 32'hffffe01c;
    localparam logic [31:0] IMC_RESET_VALUE   = 32'h00000000;
    localparam logic [7:0]  IMC_FIELD_MASK    = 8'h77;
    localparam int          IMC_LEVEL_LSB     = 0;
    localparam int          IMC_DMA_BIT       = 4;
    localparam int          IMC_STATE_LSB     = 5;
    localparam logic [1:0]  IMC_STATE_RISING  = 2'h3;
    localparam logic [1:0]  IMC_STATE_HIGH    = 2'h1;
    localparam logic [2:0]  IMC_LEVEL_OFF     = 3'h0;
    localparam logic [1:0]  IMC_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  IMC_RESP_SLVERR   = 2'h2;
    localparam int          IMC_NUM_SRC       = 6;
    localparam int          IMC_FIRST_SRC     = 26;
endpackage

// file: logic/imc_source_slot.sv
`timescale 1ns/1ps
module imc_source_slot
    import imc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [7:0] field,
    input  wire logic       req,
    output logic            irqActive,
    output logic [2:0]      irqLevel,
    output logic            dmaTrig,
    output logic [2:0]      dmaChannel
);
    logic reqDly;
    logic next_reqDly;
    logic [1:0] actState;
    logic       dmaSel;
    logic [2:0] lvl;
    logic       hit;

    assign actState = field[IMC_STATE_LSB +: 2];
    assign dmaSel   = field[IMC_DMA_BIT];
    assign lvl      = field[IMC_LEVEL_LSB +: 3];

    always_comb begin
        next_reqDly = req;
        case (actState)
            IMC_STATE_RISING: hit = req & ~reqDly;       // [R2]
            IMC_STATE_HIGH:   hit = req;                 // [R3]
            default:          hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reqDly     <= 1'b0;
            irqActive  <= 1'b0;
            irqLevel   <= 3'h0;
            dmaTrig    <= 1'b0;
            dmaChannel <= 3'h0;
        end else begin
            reqDly     <= next_reqDly;
            // Level 000 disables the source as an interrupt
            irqActive  <= hit & ~dmaSel & (lvl != IMC_LEVEL_OFF); // [R6]
            irqLevel   <= dmaSel ? 3'h0 : lvl;                    // [R6]
            dmaTrig    <= hit & dmaSel;                           // [R5]
            dmaChannel <= dmaSel ? lvl : 3'h0;                    // [R7]
        end
    end
endmodule

// file: logic/interrupt_mode_control.sv
// How it works
// R1: reserved bits always read as zero
// R2: sources 26,27 code 11 means rising edge
// R3: sources 28-31 code 01 means high level
// R4: software programs state bits before enabling
// R5: trigger bit routes source to DMA
// R6: level 000 disables, 1-7 sets priority
// R7: with trigger set, level picks DMA channel
// R8: one byte per source, fixed layout
// R9: upper byte of 26 word serves source 27
// R10: 28-31 word bytes low to high; reset zero
`timescale 1ns/1ps
module interrupt_mode_control
    import imc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [5:0]  srcReq,
    output logic [5:0]       irqActive,
    output logic [17:0]      irqLevel,
    output logic [5:0]       dmaTrig,
    output logic [17:0]      dmaChannel
);
    logic [31:0] modeLo;
    logic [31:0] modeHi;
    logic [31:0] next_modeLo;
    logic [31:0] next_modeHi;
    logic [31:0] awAddr;
    logic [31:0] next_awAddr;
    logic        awHeld;
    logic        next_awHeld;
    logic [31:0] wData;
    logic [31:0] next_wData;
    logic [3:0]  wStrb;
    logic [3:0]  next_wStrb;
    logic        wHeld;
    logic        next_wHeld;
    logic        next_awready;
    logic        next_wready;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_arready;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic [47:0] fields;
    logic [31:0] wMask;
    logic        wrToLo;
    logic        wrToHi;
    logic        rdFromLo;
    logic        rdFromHi;
    logic [7:0]  fld26;
    logic [7:0]  fld27;
    logic [7:0]  fld28;
    logic [7:0]  fld29;
    logic [7:0]  fld30;
    logic [7:0]  fld31;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wMask[b*8 +: 8] = wStrb[b] ? IMC_FIELD_MASK : 8'h00;   // [R1]
        end
    end

    // Word decode: the two byte-lane address bits are ignored
    always_comb begin
        wrToLo   = ({awAddr[31:2], 2'b00} == IMC_SRC26_27_ADDR);
        wrToHi   = ({awAddr[31:2], 2'b00} == IMC_SRC28_31_ADDR);
        rdFromLo = ({s_axi_araddr[31:2], 2'b00} == IMC_SRC26_27_ADDR);
        rdFromHi = ({s_axi_araddr[31:2], 2'b00} == IMC_SRC28_31_ADDR);
    end

    always_comb begin
        next_awAddr  = awAddr;
        next_awHeld  = awHeld;
        next_wData   = wData;
        next_wStrb   = wStrb;
        next_wHeld   = wHeld;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_modeLo  = modeLo;
        next_modeHi  = modeHi;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awAddr = s_axi_awaddr;
            next_awHeld = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
            next_wHeld = 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (awHeld && wHeld && !s_axi_bvalid) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = IMC_RESP_OKAY;
            // Only defined bits of strobed bytes take the write; reserved bits stay zero
            if (wrToLo) begin
                next_modeLo = (modeLo & ~wMask) | (wData & wMask); // [R8] [R9]
            end else if (wrToHi) begin
                next_modeHi = (modeHi & ~wMask) | (wData & wMask); // [R8] [R10]
            end else begin
                // Unmapped word: nothing stored, error returned
                next_bresp = IMC_RESP_SLVERR;
            end
        end
        // Source 26-27 word only holds the upper two bytes
        next_modeLo[15:0] = 16'h0000;
        // One write outstanding: hold off a new address until response drains
        next_awready = !next_awHeld && !next_bvalid;
        next_wready  = !next_wHeld && !next_bvalid;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            modeLo        <= IMC_RESET_VALUE;                       // [R10]
            modeHi        <= IMC_RESET_VALUE;                       // [R10]
            awAddr        <= 32'h00000000;
            awHeld        <= 1'b0;
            wData         <= 32'h00000000;
            wStrb         <= 4'h0;
            wHeld         <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= IMC_RESP_OKAY;
        end else begin
            modeLo        <= next_modeLo;
            modeHi        <= next_modeHi;
            awAddr        <= next_awAddr;
            awHeld        <= next_awHeld;
            wData         <= next_wData;
            wStrb         <= next_wStrb;
            wHeld         <= next_wHeld;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
        end
    end

    always_comb begin
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = IMC_RESP_OKAY;
            if (rdFromLo) begin
                next_rdata = modeLo;                                 // [R1]
            end else if (rdFromHi) begin
                next_rdata = modeHi;                                 // [R1]
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = IMC_RESP_SLVERR;
            end
        end
        if (!s_axi_rvalid && !s_axi_arready && !(s_axi_arvalid && s_axi_arready)) begin
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= IMC_RESP_OKAY;
        end else begin
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // Sources 26,27 from the upper half of the low word, then 28..31
    assign fields = {modeHi, modeLo[31:16]};                         // [R9] [R10]

    // Edge sources know only the rising code; any other code keeps them
    // quiet, so nothing fires before software sets the code [R4]
    always_comb begin
        fld26 = fields[7:0];
        fld27 = fields[15:8];
        if (fld26[IMC_STATE_LSB +: 2] != IMC_STATE_RISING) begin
            fld26[IMC_STATE_LSB +: 2] = 2'h0;                          // [R2]
        end
        if (fld27[IMC_STATE_LSB +: 2] != IMC_STATE_RISING) begin
            fld27[IMC_STATE_LSB +: 2] = 2'h0;                          // [R2]
        end
    end

    // Level sources know only the high-level code
    always_comb begin
        fld28 = fields[23:16];
        fld29 = fields[31:24];
        fld30 = fields[39:32];
        fld31 = fields[47:40];
        if (fld28[IMC_STATE_LSB +: 2] != IMC_STATE_HIGH) begin
            fld28[IMC_STATE_LSB +: 2] = 2'h0;                          // [R3]
        end
        if (fld29[IMC_STATE_LSB +: 2] != IMC_STATE_HIGH) begin
            fld29[IMC_STATE_LSB +: 2] = 2'h0;                          // [R3]
        end
        if (fld30[IMC_STATE_LSB +: 2] != IMC_STATE_HIGH) begin
            fld30[IMC_STATE_LSB +: 2] = 2'h0;                          // [R3]
        end
        if (fld31[IMC_STATE_LSB +: 2] != IMC_STATE_HIGH) begin
            fld31[IMC_STATE_LSB +: 2] = 2'h0;                          // [R3]
        end
    end

    // Timer sources 26 and 27, edge detected
    imc_source_slot u_slot26 (
        .clock      (clock),
        .rst_b      (rst_b),
        .field      (fld26),
        .req        (srcReq[0]),
        .irqActive  (irqActive[0]),
        .irqLevel   (irqLevel[2:0]),
        .dmaTrig    (dmaTrig[0]),
        .dmaChannel (dmaChannel[2:0])
    );

    imc_source_slot u_slot27 (
        .clock      (clock),
        .rst_b      (rst_b),
        .field      (fld27),
        .req        (srcReq[1]),
        .irqActive  (irqActive[1]),
        .irqLevel   (irqLevel[5:3]),
        .dmaTrig    (dmaTrig[1]),
        .dmaChannel (dmaChannel[5:3])
    );

    // Sources 28 to 31, level detected
    imc_source_slot u_slot28 (
        .clock      (clock),
        .rst_b      (rst_b),
        .field      (fld28),
        .req        (srcReq[2]),
        .irqActive  (irqActive[2]),
        .irqLevel   (irqLevel[8:6]),
        .dmaTrig    (dmaTrig[2]),
        .dmaChannel (dmaChannel[8:6])
    );

    imc_source_slot u_slot29 (
        .clock      (clock),
        .rst_b      (rst_b),
        .field      (fld29),
        .req        (srcReq[3]),
        .irqActive  (irqActive[3]),
        .irqLevel   (irqLevel[11:9]),
        .dmaTrig    (dmaTrig[3]),
        .dmaChannel (dmaChannel[11:9])
    );

    imc_source_slot u_slot30 (
        .clock      (clock),
        .rst_b      (rst_b),
        .field      (fld30),
        .req        (srcReq[4]),
        .irqActive  (irqActive[4]),
        .irqLevel   (irqLevel[14:12]),
        .dmaTrig    (dmaTrig[4]),
        .dmaChannel (dmaChannel[14:12])
    );

    imc_source_slot u_slot31 (
        .clock      (clock),
        .rst_b      (rst_b),
        .field      (fld31),
        .req        (srcReq[5]),
        .irqActive  (irqActive[5]),
        .irqLevel   (irqLevel[17:15]),
        .dmaTrig    (dmaTrig[5]),
        .dmaChannel (dmaChannel[17:15])
    );
endmodule

// file: test/imc_checker.sv
`timescale 1ns/1ps
module imc_checker (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [5:0]  srcReq,
    input  wire logic [5:0]  irqActive,
    input  wire logic [17:0] irqLevel,
    input  wire logic [5:0]  dmaTrig,
    input  wire logic [17:0] dmaChannel,
    input  wire logic        s_axi_rvalid,
    input  wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_rise0;
        !srcReq[0] ##1 srcReq[0];
    endsequence
    a_rsv_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'h88888888) == 32'h0)
        else $error("reserved bit set");
    a_edge_once: assert property (s_rise0 ##1 irqActive[0] |=> !irqActive[0])
        else $error("pulse too long");
    a_edge_cause: assert property (
        $rose(irqActive[0]) |-> $past(srcReq[0]) && !$past(srcReq[0], 2))
        else $error("pulse without edge");
    a_level_cause: assert property (irqActive[2] |-> $past(srcReq[2]))
        else $error("active without request");
    a_dma_excl: assert property ((irqActive & dmaTrig) == 6'h00)
        else $error("irq and dma together");
    a_prio_set: assert property (irqActive[5] |-> irqLevel[17:15] != 3'h0)
        else $error("active with level off");
    a_chan_only: assert property (dmaChannel[17:15] != 3'h0 |-> irqLevel[17:15] == 3'h0)
        else $error("channel with priority");
    a_reset_zero: assert property (
        $rose(rst_b) |-> irqActive == 6'h00 && dmaTrig == 6'h00 && !s_axi_rvalid)
        else $error("outputs set after reset");
endmodule

// file: test/imc_src_model.sv
`timescale 1ns/1ps
module imc_src_model (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic [5:0] want,
    output logic [5:0]      srcReq
);
    // Timer lines only move after an edge, so edges are clean 0 to 1 steps
    always @(posedge clock) begin
        srcReq <= rst_b ? want : 6'h00;
    end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin errors++; \
    $display("wrong value %s exp %h seen %h", n, e, v); end end
module testbench
    import imc_pkg::*;
;
    localparam logic [31:0] A26 = IMC_SRC26_27_ADDR;
    localparam logic [31:0] A28 = IMC_SRC28_31_ADDR;
    localparam logic [1:0]  OK  = IMC_RESP_OKAY;
    logic        clock = 1'b0, rst_b = 1'b0;
    logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic        awReady, wReady, bValid, arReady, rValid;
    logic [31:0] awAddr = 32'h0, wData = 32'h0, arAddr = 32'h0, rData;
    logic [3:0]  wStrb = 4'h0;
    logic [1:0]  bResp, rResp;
    logic [5:0]  want = 6'h00, srcReq, irqActive, dmaTrig;
    logic [17:0] irqLevel, dmaChannel;
    int          errors = 0, checked = 0;
    always #50 clock = ~clock;
    imc_src_model u_src (.clock(clock), .rst_b(rst_b), .want(want), .srcReq(srcReq));
    interrupt_mode_control u_dut (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .srcReq(srcReq), .irqActive(irqActive),
        .irqLevel(irqLevel), .dmaTrig(dmaTrig), .dmaChannel(dmaChannel));
    task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
        awAddr <= a;
        wData <= d;
        wStrb <= s;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        @(posedge clock);
        while (bReady) begin
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
            if (bValid) begin
                bReady <= 1'b0;
                `CHK("bresp", er, bResp)
            end
            @(posedge clock);
        end
    endtask
    task automatic rd(input logic [31:0] a, e, input logic [1:0] er);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        @(posedge clock);
        while (rReady) begin
            if (arReady) arValid <= 1'b0;
            if (rValid) begin
                rReady <= 1'b0;
                `CHK("rdata", e, rData)
                `CHK("rresp", er, rResp)
            end
            @(posedge clock);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic t_regs();
        rd(A28, IMC_RESET_VALUE, OK);
        rd(A26, IMC_RESET_VALUE, OK);
        wr(32'hffffe000, 32'hffffffff, 4'hf, IMC_RESP_SLVERR);
        rd(32'hffffe000, 32'h0, IMC_RESP_SLVERR);
        wr(A28, 32'hffffffff, 4'hf, OK);
        rd(A28, 32'h77777777, OK);
        wr(A28, 32'h0, 4'h2, OK);
        rd(A28, 32'h77770077, OK);
        wr(A26, 32'hffffffff, 4'hf, OK);
        rd(A26, 32'h77770000, OK);
        $display("regs done");
    endtask
    task automatic t_level();
        wr(A28, 32'h07050301, 4'hf, OK);
        want <= 6'h3c;
        settle(3);
        `CHK("unset state", 6'h00, irqActive)
        @(posedge clock);
        wr(A28, 32'h27252320, 4'hf, OK);
        settle(2);
        `CHK("level act", 6'h38, irqActive)
        `CHK("level prio", 12'hf58, irqLevel[17:6])
        @(posedge clock);
        wr(A28, 32'h27252321, 4'hf, OK);
        settle(2);
        `CHK("level on", 6'h3c, irqActive)
        @(posedge clock);
        want <= 6'h00;
        $display("level done");
    endtask
    task automatic t_edge();
        wr(A26, 32'h62610000, 4'hf, OK);
        want <= 6'h03;
        settle(2);
        `CHK("pulse", 2'h3, irqActive[1:0])
        `CHK("edge prio", 6'h11, irqLevel[5:0])
        @(negedge clock);
        `CHK("pulse end", 2'h0, irqActive[1:0])
        @(posedge clock);
        want <= 6'h00;
        $display("edge done");
    endtask
    task automatic t_dma();
        want <= 6'h20;
        for (int ch = 0; ch < 8; ch++) begin
            wr(A28, {8'h30 | 8'(ch), 24'h0}, 4'hf, OK);
            settle(2);
            `CHK("dma trig", 2'h2, {dmaTrig[5], irqActive[5]})
            `CHK("dma chan", 3'(ch), dmaChannel[17:15])
            @(posedge clock);
        end
        want <= 6'h00;
        $display("dma done");
    endtask
    task automatic give_verdict();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        t_regs();
        t_level();
        t_edge();
        t_dma();
        give_verdict();
    end
    // Over ten times the expected run, so a stuck handshake ends the run
    initial begin
        repeat (2000) @(posedge clock);
        errors++;
        give_verdict();
    end
endmodule
bind interrupt_mode_control imc_checker u_chk (.clock(clock), .rst_b(rst_b), .srcReq(srcReq),
    .irqActive(irqActive), .irqLevel(irqLevel), .dmaTrig(dmaTrig), .dmaChannel(dmaChannel),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));
